// ==== logic/fsb_pkg.sv ====
// Shared constants, types and burst ordering for the flow-through burst SRAM port.
package fsb_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int ADDR_W  = 18;
  localparam int BURST_W = 2;
  localparam int LANES   = 4;
  localparam int LANE_W  = 8;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int DEPTH   = 1 << ADDR_W;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [ADDR_W-1:0]  ADDR_RESET  = 18'h00000;
  localparam logic [BURST_W-1:0] BURST_RESET = 2'h0;
  localparam logic [DATA_W-1:0]  DATA_RESET  = 32'h00000000;
  localparam logic [LANES-1:0]   LANE_RESET  = 4'h0;
  localparam logic [1:0]         SYNC_RESET  = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE   = 2'h1;
  // Sleep entry and exit both take this many clocks of synchronising.
  localparam int SLEEP_SYNC_CYCLES = 2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic {FSB_LINEAR, FSB_INTERLEAVED} fsb_order_t;
  typedef enum logic [1:0] {FSB_IDLE, FSB_ACTIVE, FSB_SLEEP} fsb_state_t;

  // Address within a four-beat burst after a number of steps.
  function automatic logic [BURST_W-1:0] fsb_burst_addr(input logic [BURST_W-1:0] start,
                                                        input logic [BURST_W-1:0] steps,
                                                        input fsb_order_t         order);
    logic [BURST_W-1:0] sum;
    sum = start + steps;
    fsb_burst_addr = (order == FSB_INTERLEAVED) ? (start ^ steps) : sum;
  endfunction

endpackage

// ==== logic/fsb_burst_counter.sv ====
// Two-bit wrapping burst counter with linear and interleaved order.
module fsb_burst_counter
  import fsb_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire logic               load,
  input  wire logic               step,
  input  wire logic [BURST_W-1:0] start,
  input  wire fsb_order_t         order,
  output logic      [BURST_W-1:0] count,
  output logic      [BURST_W-1:0] count_next
);

  logic [BURST_W-1:0] start_reg;
  logic [BURST_W-1:0] start_next;
  logic [BURST_W-1:0] steps_reg;
  logic [BURST_W-1:0] steps_next;

  // ****************************************************************
  // Counting
  // ****************************************************************
  // wrap within four beats.
  assign steps_next = load ? BURST_RESET : (step ? steps_reg + BURST_ONE : steps_reg);
  assign start_next = load ? start : start_reg;
  assign count      = fsb_burst_addr(start_reg, steps_reg, order);
  assign count_next = fsb_burst_addr(start_next, steps_next, order);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      start_reg <= BURST_RESET;
      steps_reg <= BURST_RESET;
    end else begin
      start_reg <= start_next;
      steps_reg <= steps_next;
    end
  end

endmodule

// ==== logic/fsb_port.sv ====
// Device side of a flow-through burst SRAM port with its storage array.
// What this block does
// - Processor strobe loads address and burst counter.
// - Controller strobe loads address and burst counter.
// - Both strobes low: processor strobe only.
// - Processor strobe ignored while primary select high.
// - Sleep input enters data-keeping low power.
// - Write data captured on rising clock edge.
// - Reads drive addressed data with no output stage.
// - Output enable sets data direction asynchronously.
// - Outputs float on writes, emerging and deselect.
// - Parity lanes follow data, written per lane.
// - Strap picks linear or interleaved order.
// - Test output changes on falling test clock.
// - Test inputs sampled on rising test clock.
// - Global write writes every byte lane.
// - Chip selects evaluated only on address loads.
// - Burst counter advances when step input low.
// - Output enable masked first clock after deselect.
module fsb_port
  import fsb_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              processor_address_strobe_n,
  input  wire logic              controller_address_strobe_n,
  input  wire logic              burst_step_n,
  input  wire logic              primary_chip_select_n,
  input  wire logic              high_chip_select,
  input  wire logic              third_chip_select_n,
  input  wire logic              global_write_n,
  input  wire logic              byte_write_enable_n,
  input  wire logic [LANES-1:0]  byte_lane_select_n,
  input  wire logic              output_enable_n,
  input  wire logic              sleep_request,
  input  wire logic              burst_order_strap,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic      [DATA_W-1:0] dq_oe,
  input  wire logic [LANES-1:0]  parity_io_lines_in,
  output logic      [LANES-1:0]  parity_io_lines_out,
  output logic      [LANES-1:0]  parity_io_lines_oe,
  output logic                   sleep_active,
  input  wire logic              test_clk,
  input  wire logic              test_data_in,
  input  wire logic              test_mode_select,
  output logic                   test_data_out
);

  fsb_state_t                 state_reg;
  fsb_state_t                 state_next;
  fsb_order_t                 order_reg;
  logic                       strap_done_reg;
  logic [1:0]                 sleep_sync_reg;
  logic [ADDR_W-1:BURST_W]    addr_reg;
  logic [BURST_W-1:0]         count;
  logic [BURST_W-1:0]         count_next;
  logic                       drive_allow_reg;
  logic                       wr_pend_reg;
  logic [ADDR_W-1:0]          wr_addr_reg;
  logic [LANES-1:0]           wr_lane_reg;
  logic [DATA_W-1:0]          data_reg;
  logic [LANES-1:0]           parity_reg;
  logic                       tck_prev_reg;
  logic                       bypass_reg;
  logic                       tdo_reg;
  logic                       sleep_active_reg;

  wire logic                  awake;
  wire logic                  cs_ok;
  wire logic                  processor_address_strobe_take;
  wire logic                  controller_address_strobe_take;
  wire logic                  load;
  wire logic                  step;
  wire logic                  write_req;
  wire logic                  do_write;
  wire logic                  emerging;
  wire logic [LANES-1:0]      lane_we;
  wire logic [ADDR_W-1:0]     cur_addr;
  wire logic [ADDR_W-1:0]     next_addr;
  wire logic                  tck_rise;
  wire logic                  tck_fall;

  // ****************************************************************
  // Strobe decode
  // ****************************************************************
  assign awake = ~sleep_sync_reg[1] & (state_reg != FSB_SLEEP);
  // selects count only with a load.
  assign cs_ok = ~primary_chip_select_n & high_chip_select & ~third_chip_select_n;
  assign processor_address_strobe_take = ~processor_address_strobe_n & ~primary_chip_select_n & awake;
  assign controller_address_strobe_take = ~controller_address_strobe_n & processor_address_strobe_n & awake;
  assign load = processor_address_strobe_take | controller_address_strobe_take;
  assign step = ~burst_step_n & ~load & awake & (state_reg == FSB_ACTIVE);

  // ****************************************************************
  // Write qualification
  // ****************************************************************
  // global write takes all lanes.
  assign lane_we = ~global_write_n ? {LANES{1'b1}} :
                   (~byte_write_enable_n ? ~byte_lane_select_n : LANE_RESET);
  assign write_req = |lane_we;
  // A processor-strobe load ignores write inputs on its own edge.
  assign do_write  = write_req & ~processor_address_strobe_take & (state_next == FSB_ACTIVE);
  assign emerging  = load & cs_ok & (state_reg != FSB_ACTIVE);
  assign cur_addr  = {addr_reg, count};
  assign next_addr = load ? addr : {addr_reg, count_next};

  // ****************************************************************
  // Selection state
  // ****************************************************************
  // sleep keeps contents, stops access.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FSB_IDLE: begin
        if (sleep_sync_reg[1]) begin
          state_next = FSB_SLEEP;
        end else if (load & cs_ok) begin
          state_next = FSB_ACTIVE;
        end
      end
      FSB_ACTIVE: begin
        if (sleep_sync_reg[1]) begin
          state_next = FSB_SLEEP;
        end else if (load & ~cs_ok) begin
          state_next = FSB_IDLE;
        end
      end
      FSB_SLEEP: begin
        if (!sleep_sync_reg[1]) begin
          state_next = FSB_IDLE;
        end
      end
    endcase
  end

  // Sleep is asynchronous, so it is brought in through two flops.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sleep_sync_reg   <= SYNC_RESET;
      state_reg        <= FSB_IDLE;
      sleep_active_reg <= 1'b0;
    end else begin
      sleep_sync_reg   <= {sleep_sync_reg[0], sleep_request};
      state_reg        <= state_next;
      sleep_active_reg <= (state_next == FSB_SLEEP);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strap_done_reg <= 1'b0;
      order_reg      <= FSB_INTERLEAVED;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      order_reg      <= burst_order_strap ? FSB_INTERLEAVED : FSB_LINEAR;
    end
  end

  // ****************************************************************
  // Address and burst counter
  // ****************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= ADDR_RESET[ADDR_W-1:BURST_W];
    end else if (load) begin
      addr_reg <= addr[ADDR_W-1:BURST_W];
    end
  end

  fsb_burst_counter u_counter (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .load       (load),
    .step       (step),
    .start      (addr[BURST_W-1:0]),
    .order      (order_reg),
    .count      (count),
    .count_next (count_next)
  );

  // ****************************************************************
  // Write data path
  // ****************************************************************
  // data into data register, parity into parity register.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= ADDR_RESET;
      wr_lane_reg <= LANE_RESET;
      data_reg    <= DATA_RESET;
      parity_reg  <= LANE_RESET;
    end else begin
      wr_pend_reg <= do_write;
      if (do_write) begin
        wr_addr_reg <= next_addr;
        wr_lane_reg <= lane_we;
        data_reg    <= dq_in;
        parity_reg  <= parity_io_lines_in;
      end
    end
  end

  // The array is written one clock after capture; reads of that word are forwarded
  // from the data register so a read straight after a write sees the new bytes.
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane++) begin : g_lane
      logic [LANE_W:0] lane_mem [0:DEPTH-1];
      wire logic [LANE_W:0] stored;
      wire logic [LANE_W:0] fwd;
      wire logic            hit;
      assign stored = lane_mem[cur_addr];
      assign hit    = wr_pend_reg & wr_lane_reg[lane] & (wr_addr_reg == cur_addr);
      assign fwd    = {parity_reg[lane], data_reg[lane*LANE_W +: LANE_W]};
      always_ff @(posedge core_clk) begin
        if (wr_pend_reg & wr_lane_reg[lane]) begin
          lane_mem[wr_addr_reg] <= fwd;
        end
      end
      assign dq_out[lane*LANE_W +: LANE_W] = hit ? fwd[LANE_W-1:0] : stored[LANE_W-1:0];
      assign parity_io_lines_out[lane]     = hit ? fwd[LANE_W] : stored[LANE_W];
    end
  endgenerate

  // ****************************************************************
  // Output drive
  // ****************************************************************
  // float on write and deselect.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drive_allow_reg <= 1'b0;
    end else begin
      drive_allow_reg <= (state_next == FSB_ACTIVE) & ~do_write & ~emerging;
    end
  end

  // output enable acts without the clock.
  assign dq_oe              = {DATA_W{drive_allow_reg & ~output_enable_n}};
  assign parity_io_lines_oe = {LANES{drive_allow_reg & ~output_enable_n}};
  assign sleep_active       = sleep_active_reg;

  // ****************************************************************
  // Test access pins
  // ****************************************************************
  assign tck_rise = test_clk & ~tck_prev_reg;
  assign tck_fall = ~test_clk & tck_prev_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tck_prev_reg <= 1'b0;
      bypass_reg   <= 1'b0;
      tdo_reg      <= 1'b0;
    end else begin
      tck_prev_reg <= test_clk;
      if (tck_rise & ~test_mode_select) begin
        bypass_reg <= test_data_in;
      end
      if (tck_fall) begin
        tdo_reg <= bypass_reg;
      end
    end
  end
  assign test_data_out = tdo_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence load_sel_s;
    load & cs_ok;
  endsequence

  processor_address_strobe_load_a: assert property (processor_address_strobe_take & cs_ok |=> cur_addr == $past(addr))
    else $error("processor strobe did not load the address");
  controller_address_strobe_load_a: assert property (controller_address_strobe_take & cs_ok |=> cur_addr == $past(addr))
    else $error("controller strobe did not load the address");
  strobe_prio_a: assert property (~processor_address_strobe_n & ~controller_address_strobe_n
      & primary_chip_select_n & burst_step_n & (state_reg == FSB_ACTIVE) & awake
      |=> cur_addr == $past(cur_addr) && state_reg == FSB_ACTIVE)
    else $error("controller strobe acted while processor strobe low");
  burst_step_a: assert property ((state_reg == FSB_ACTIVE) & awake & ~burst_step_n & ~load
      & (order_reg == FSB_LINEAR) |=> count == $past(count) + BURST_ONE)
    else $error("burst counter did not advance");
  write_float_a: assert property (do_write |=> !drive_allow_reg && wr_pend_reg)
    else $error("data lines driven during a write");
  emerge_mask_a: assert property (load_sel_s ##0 (state_reg == FSB_IDLE)
      |=> !drive_allow_reg)
    else $error("output not masked after deselect");
  global_wr_a: assert property (~global_write_n & do_write |=> &wr_lane_reg)
    else $error("global write missed a lane");
  data_cap_a: assert property (do_write |=> data_reg == $past(dq_in))
    else $error("write data not captured");
  sleep_enter_a: assert property (sleep_request [*3] |=> sleep_active && !drive_allow_reg)
    else $error("sleep not entered after two sync clocks");
  tdo_fall_a: assert property (tck_fall |=> test_data_out == $past(bypass_reg))
    else $error("test output did not follow falling edge");

endmodule

// ==== tb/fsb_host_lines.sv ====
// Bus master side of the shared data lines, resolving the level every party sees.
module fsb_host_lines #(
  parameter int W = 32
) (
  input  wire logic         core_clk,
  input  wire logic [W-1:0] dev_out,
  input  wire logic [W-1:0] dev_oe,
  input  wire logic [W-1:0] host_data,
  input  wire logic         host_en,
  output logic      [W-1:0] wire_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // Undriven lines toggle each clock, so a stale value can never pass for real data.
  logic [W-1:0] float_reg = {W{1'b0}};

  always_ff @(posedge core_clk) begin
    float_reg <= ~float_reg;
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (dev_oe[i]) begin
        wire_level[i] = dev_out[i];
      end else if (host_en) begin
        wire_level[i] = host_data[i];
      end else begin
        wire_level[i] = float_reg[i];
      end
    end
  end
endmodule

// ==== tb/fsb_port_tb_top.sv ====
// Self-checking bench for the flow-through burst SRAM port.
module fsb_port_tb_top
  import fsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [ADDR_W-1:0] A1 = 18'h00010;
  localparam logic [ADDR_W-1:0] A2 = 18'h00020;
  localparam logic [DATA_W-1:0] D1 = 32'h11223344;
  localparam logic [DATA_W-1:0] D2 = 32'haabbccdd;
  localparam logic [DATA_W-1:0] D3 = 32'h0f1e2d3c;
  localparam logic [DATA_W-1:0] E1 = 32'h11bb33dd;
  localparam logic [DATA_W-1:0] ON = 32'hffffffff;

  logic              core_clk = 1'b0;
  logic              nrst, processor_address_strobe_n, controller_address_strobe_n;
  logic              burst_step_n, primary_chip_select_n, high_chip_select;
  logic              third_chip_select_n, global_write_n, byte_write_enable_n;
  logic              output_enable_n, sleep_request, burst_order_strap, sleep_active;
  logic              test_clk, test_data_in, test_mode_select, test_data_out, host_en;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0]  byte_lane_select_n, parity_io_lines_in, parity_io_lines_out;
  logic [LANES-1:0]  parity_io_lines_oe, host_par;
  logic [DATA_W-1:0] dq_in, dq_out, dq_oe, host_dq;
  int                num_errors = 0;
  int                samples_checked = 0;

  fsb_port uut (.*);
  fsb_host_lines #(.W(DATA_W)) dq_lines (.core_clk(core_clk), .dev_out(dq_out), .dev_oe(dq_oe),
    .host_data(host_dq), .host_en(host_en), .wire_level(dq_in));
  fsb_host_lines #(.W(LANES)) par_lines (.core_clk(core_clk), .dev_out(parity_io_lines_out),
    .dev_oe(parity_io_lines_oe), .host_data(host_par), .host_en(host_en),
    .wire_level(parity_io_lines_in));

  always #2 core_clk = ~core_clk;

  task automatic final_report();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic load(input logic [ADDR_W-1:0] a, input logic p, input logic c);
    addr = a;
    processor_address_strobe_n = p;
    controller_address_strobe_n = c;
    cyc();
    processor_address_strobe_n = 1'b1;
    controller_address_strobe_n = 1'b1;
  endtask

  // byte writes need the enable low with lane selects; outputs released first.
  task automatic put(input logic [DATA_W-1:0] d, input logic [LANES-1:0] p, input logic g,
                     input logic [LANES-1:0] ln);
    host_dq = d;
    host_par = p;
    host_en = 1'b1;
    output_enable_n = 1'b1;
    global_write_n = g;
    byte_write_enable_n = ~g;
    byte_lane_select_n = ln;
  endtask

  task automatic idle_bus();
    host_en = 1'b0;
    output_enable_n = 1'b0;
    global_write_n = 1'b1;
    byte_write_enable_n = 1'b1;
    byte_lane_select_n = 4'hf;
  endtask

  task automatic wr_p(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [LANES-1:0] p, input logic g, input logic [LANES-1:0] ln);
    load(a, 1'b0, 1'b1);
    put(d, p, g, ln);
    cyc();
    idle_bus();
    #1;
    chk(dq_oe, '0);
  endtask

  task automatic wr_c(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    put(d, 4'h0, 1'b0, 4'hf);
    load(a, 1'b1, 1'b0);
    idle_bus();
    // An idle edge keeps the next request from re-driving lines released in this step.
    cyc();
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [LANES-1:0] p);
    load(a, 1'b0, 1'b1);
    chk(dq_out, d);
    chk(parity_io_lines_out, p);
    cyc();
    chk(dq_oe, ON);
  endtask

  task automatic t_rw();
    wr_p(A1, D1, 4'h5, 1'b0, 4'hf);
    rd(A1, D1, 4'h5);
    output_enable_n = 1'b1;
    #1;
    chk(dq_oe, '0);
    chk(parity_io_lines_oe, '0);
    output_enable_n = 1'b0;
    #1;
    chk(parity_io_lines_oe, 4'hf);
  endtask

  task automatic t_bytes();
    wr_p(A1, D2, 4'ha, 1'b1, 4'b1010);
    rd(A1, E1, 4'h0);
  endtask

  task automatic t_controller_address_strobe();
    wr_c(A2, D3);
    rd(A2, D3, 4'h0);
    put(D2, 4'h0, 1'b0, 4'hf);
    load(A2, 1'b0, 1'b0);
    idle_bus();
    cyc();
    chk(dq_out, D3);
  endtask

  task automatic t_cs();
    primary_chip_select_n = 1'b1;
    load(A1, 1'b0, 1'b1);
    chk(dq_out, D3);
    burst_step_n = 1'b0;
    cyc();
    burst_step_n = 1'b1;
    load(A1, 1'b0, 1'b0);
    cyc();
    chk(dq_oe, ON);
    load(A1, 1'b1, 1'b0);
    primary_chip_select_n = 1'b0;
    cyc();
    chk(dq_oe, '0);
    load(A1, 1'b0, 1'b1);
    chk(dq_oe, '0);
    chk(dq_out, E1);
    cyc();
    chk(dq_oe, ON);
  endtask

  task automatic t_burst(input logic o);
    logic [1:0] idx;
    for (int i = 0; i < 4; i++) begin
      wr_c(18'h00100 + 18'(i), 32'h5a5a0000 + 32'(i));
    end
    load(18'h00101, 1'b0, 1'b1);
    burst_step_n = 1'b0;
    for (int s = 0; s < 4; s++) begin
      idx = o ? (2'h1 ^ 2'(s)) : (2'h1 + 2'(s));
      chk(dq_out, 32'h5a5a0000 + 32'(idx));
      cyc();
    end
    burst_step_n = 1'b1;
  endtask

  task automatic t_sleep();
    high_chip_select = 1'b0;
    load(A1, 1'b1, 1'b0);
    high_chip_select = 1'b1;
    sleep_request = 1'b1;
    cyc(4);
    chk(sleep_active, 1'b1);
    chk(dq_oe, '0);
    wr_c(A1, D2);
    // sleep held low for normal work
    sleep_request = 1'b0;
    cyc(3);
    chk(sleep_active, 1'b0);
    rd(A1, E1, 4'h0);
  endtask

  task automatic t_test();
    test_data_in = 1'b1;
    test_clk = 1'b1;
    cyc(3);
    test_clk = 1'b0;
    cyc(3);
    chk(test_data_out, 1'b1);
    test_data_in = 1'b0;
    test_clk = 1'b1;
    cyc(3);
    chk(test_data_out, 1'b1);
    test_clk = 1'b0;
    cyc(3);
    chk(test_data_out, 1'b0);
    test_mode_select = 1'b1;
    test_data_in = 1'b1;
    test_clk = 1'b1;
    cyc(3);
    test_clk = 1'b0;
    cyc(3);
    chk(test_data_out, 1'b0);
    test_mode_select = 1'b0;
  endtask

  // strap only changes while the port is held in reset.
  task automatic rst(input logic strap);
    nrst = 1'b0;
    burst_order_strap = strap;
    cyc(6);
    nrst = 1'b1;
    cyc(2);
  endtask

  initial begin
    #20000;
    num_errors++;
    final_report();
  end

  initial begin
    nrst = 1'b0;
    processor_address_strobe_n = 1'b1;
    controller_address_strobe_n = 1'b1;
    burst_step_n = 1'b1;
    primary_chip_select_n = 1'b0;
    high_chip_select = 1'b1;
    third_chip_select_n = 1'b0;
    idle_bus();
    sleep_request = 1'b0;
    test_clk = 1'b0;
    test_data_in = 1'b0;
    test_mode_select = 1'b0;
    addr = '0;
    host_dq = '0;
    host_par = '0;
    rst(1'b1);
    t_rw();
    t_bytes();
    t_controller_address_strobe();
    t_cs();
    t_burst(1'b1);
    t_sleep();
    t_test();
    rst(1'b0);
    t_burst(1'b0);
    final_report();
  end
endmodule
